//--- core/sdm_monitor.sv
// top of the safety input discrepancy monitor with its AXI4-Lite registers
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
module sdm_monitor
  import sdm_pkg::*;
#(
  parameter int unsigned FILT_CYC = FILT_CYC_DEF,
  parameter int unsigned DISC_CYC = DISC_CYC_DEF
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // safety input terminals
  input  wire logic [NUM_IN-1:0]    guard_input_primary_channel,
  input  wire logic [NUM_IN-1:0]    guard_input_secondary_channel,
  // safety output terminals and their read-back
  output logic [NUM_OUT-1:0]        guard_output_primary_channel,
  output logic [NUM_OUT-1:0]        guard_output_secondary_channel,
  input  wire logic [NUM_OUT-1:0]   out_readback_primary,
  input  wire logic [NUM_OUT-1:0]   out_readback_secondary,
  // single-channel inputs
  input  wire logic                 hold_release_input,
  input  wire logic                 teach_mode_in,
  // status outputs
  output logic                      motion_inhibit,
  output logic                      guard_open_status,
  output logic                      teach_latch_status,
  output logic                      estop_active,
  output logic                      discrepancy_error,
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    return (a == ADDR_FUNC) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
           (a == ADDR_IRQ_MASK) || (a == ADDR_CTRL) || (a == ADDR_OUT);
  endfunction : addr_known

  ////////////////////////////////////////////////////////////////////////////
  // channel pairs
  logic [NUM_PAIR-1:0] pri_raw, sec_raw, pri_f, sec_f, pair_err;
  logic [NUM_PAIR-1:0] pair_ok;
  // inputs in the low pairs, output read-back above them
  assign pri_raw = {out_readback_primary, guard_input_primary_channel};
  assign sec_raw = {out_readback_secondary, guard_input_secondary_channel};
  for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
    sdm_pair #(
      .FILT_CYC (FILT_CYC),
      .DISC_CYC (DISC_CYC)
    ) u_pair (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pri_raw  (pri_raw[p]),
      .sec_raw  (sec_raw[p]),
      .pri_filt (pri_f[p]),
      .sec_filt (sec_f[p]),
      .disc_err (pair_err[p])
    );
  end
  // a pair is closed only when both contacts conduct
  assign pair_ok = pri_f & sec_f;

  ////////////////////////////////////////////////////////////////////////////
  // single-channel inputs, synchronised only
  logic rel_s1_r, rel_s2_r, teach_s1_r, teach_s2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rel_s1_r   <= 1'b0;
      rel_s2_r   <= 1'b0;
      teach_s1_r <= 1'b0;
      teach_s2_r <= 1'b0;
    end else begin
      rel_s1_r   <= hold_release_input;
      rel_s2_r   <= rel_s1_r;
      teach_s1_r <= teach_mode_in;
      teach_s2_r <= teach_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and safety state
  logic [9:0]       func_r, func_nxt;
  logic [IRQ_W-1:0] ista_r, ista_nxt, imask_r, imask_nxt;
  logic [2:0]       out_r, out_nxt;
  logic             est_rst_cmd;
  logic [FCNT_W:0]  settle_r, settle_nxt;
  logic             settled;
  logic             guard_lat_r, guard_lat_nxt;
  logic             teach_lat_r, teach_lat_nxt;
  logic             estop_r, estop_nxt;
  logic             guard_open, estop_open;
  logic [IRQ_W-1:0] events;
  // filters start low and need sync plus one window, so wait two windows
  // lest closed contacts read as open and latch a stop at power-up
  assign settled = (settle_r == (FCNT_W + 1)'(FILT_CYC + FILT_CYC));
  always_comb begin
    guard_open = 1'b0;
    estop_open = 1'b0;
    // guard and stop pairs act per their configured function; speed and position pairs are not used here
    for (int i = 0; i < NUM_IN; i++) begin
      if (sdm_func_t'(func_r[2*i +: 2]) == FN_INTERLOCK_GUARD) begin
        guard_open = guard_open | ~pair_ok[i];
      end
      if (sdm_func_t'(func_r[2*i +: 2]) == FN_ESTOP) begin
        estop_open = estop_open | ~pair_ok[i];
      end
    end
    guard_open = guard_open & settled;
    estop_open = estop_open & settled;
  end
  always_comb begin
    settle_nxt = settled ? settle_r : settle_r + 1'b1;
    // one common release clears every guard latch; an open guard
    // re-latches at once, so release only sticks once closed
    guard_lat_nxt = guard_open | (guard_lat_r & ~rel_s2_r);
    teach_lat_nxt = teach_s2_r | (teach_lat_r & ~rel_s2_r);
    // stop holds until the switch is back and reset is commanded
    estop_nxt = estop_open | (estop_r & ~est_rst_cmd);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_r    <= '0;
      guard_lat_r <= 1'b0;
      teach_lat_r <= 1'b0;
      estop_r     <= 1'b0;
    end else begin
      settle_r    <= settle_nxt;
      guard_lat_r <= guard_lat_nxt;
      teach_lat_r <= teach_lat_nxt;
      estop_r     <= estop_nxt;
    end
  end
  // rising edges of the guard, teach and stop latches, and the pair error levels, become interrupt events
  assign events = {estop_nxt & ~estop_r,
                   teach_lat_nxt & ~teach_lat_r,
                   guard_lat_nxt & ~guard_lat_r,
                   pair_err};

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave, one write and one read at a time
  logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic [3:0]        wstrb_r, wstrb_nxt;
  logic              bvalid_r, bvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt;
  logic              rvalid_r, rvalid_nxt;
  logic [1:0]        rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt, status_w, wr_val;
  logic              wr_fire;
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign wr_fire       = aw_got_r & w_got_r & ~bvalid_r;
  assign wr_val        = strb_merge(32'h0000_0000, wdata_r, wstrb_r);
  always_comb begin
    status_w                         = 32'h0000_0000;
    status_w[NUM_PAIR-1:0]           = pair_err;
    status_w[ST_OK_LSB +: NUM_PAIR]  = pair_ok;
    status_w[ST_GUARD]               = guard_lat_r;
    status_w[ST_TEACH]               = teach_lat_r;
    status_w[ST_ESTOP]               = estop_r;
    status_w[ST_INHIBIT]             = motion_inhibit;
    status_w[ST_SETTLED]             = settled;
  end
  always_comb begin
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    func_nxt    = func_r;
    imask_nxt   = imask_r;
    out_nxt     = out_r;
    est_rst_cmd = 1'b0;
    // hardware set wins over a same-cycle write-one clear
    ista_nxt    = ista_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = addr_known(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      unique case (awaddr_r)
        ADDR_FUNC: begin
          func_nxt = 10'(strb_merge({22'h0, func_r}, wdata_r, wstrb_r));
        end
        ADDR_IRQ_STAT: begin
          ista_nxt = ista_r & ~wr_val[IRQ_W-1:0];
        end
        ADDR_IRQ_MASK: begin
          imask_nxt = IRQ_W'(strb_merge({21'h0, imask_r}, wdata_r, wstrb_r));
        end
        ADDR_CTRL: begin
          est_rst_cmd = wr_val[CTRL_ESTOP_RESET];
        end
        ADDR_OUT: begin
          out_nxt = 3'(strb_merge({29'h0, out_r}, wdata_r, wstrb_r));
        end
        default: begin
        end
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    ista_nxt = ista_nxt | events;
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rresp_nxt  = rresp_r;
    rdata_nxt  = rdata_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        ADDR_FUNC:     rdata_nxt = {22'h0, func_r};
        ADDR_STATUS:   rdata_nxt = status_w;
        ADDR_IRQ_STAT: rdata_nxt = {21'h0, ista_r};
        ADDR_IRQ_MASK: rdata_nxt = {21'h0, imask_r};
        ADDR_OUT:      rdata_nxt = {29'h0, out_r};
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0000_0000;
      func_r   <= FUNC_RST;
      ista_r   <= '0;
      imask_r  <= '0;
      out_r    <= OUT_RST;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r  <= rresp_nxt;
      rdata_r  <= rdata_nxt;
      func_r   <= func_nxt;
      ista_r   <= ista_nxt;
      imask_r  <= imask_nxt;
      out_r    <= out_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp  = rresp_r;
  assign s_axi_rdata  = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // any error forces the safe outputs off, both channels driven alike
  assign guard_output_primary_channel   = out_r & {NUM_OUT{~discrepancy_error}};
  assign guard_output_secondary_channel = out_r & {NUM_OUT{~discrepancy_error}};

  assign discrepancy_error  = |pair_err;
  // an open guard inhibits motion even after teach is released
  assign motion_inhibit     = guard_lat_r | guard_open | estop_r | discrepancy_error;
  assign guard_open_status  = guard_lat_r;
  assign teach_latch_status = teach_lat_r;
  assign estop_active       = estop_r;
  assign irq                = |(ista_r & imask_r);

endmodule : sdm_monitor

//--- core/sdm_pkg.sv
// constants, offsets and types shared by the discrepancy monitor files
package sdm_pkg;

  // timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;
  localparam int unsigned PULSE_MAX_US = 500;
  localparam int unsigned PULSE_GAP_MS = 20;
  localparam int unsigned DISC_TIME_S  = 2;
  // a level must outlast the widest test pulse before it is accepted
  localparam int unsigned FILT_CYC_DEF = PULSE_MAX_US * CYC_PER_US + 1;
  localparam int unsigned DISC_CYC_DEF = DISC_TIME_S * CLK_HZ;
  localparam int unsigned FCNT_W       = 17;
  localparam int unsigned DCNT_W       = 29;

  // pair counts
  localparam int unsigned NUM_IN   = 5;
  localparam int unsigned NUM_OUT  = 3;
  localparam int unsigned NUM_PAIR = NUM_IN + NUM_OUT;

  // function of an input pair
  typedef enum logic [1:0] {
    FN_ESTOP           = 2'h0,
    FN_INTERLOCK_GUARD = 2'h1,
    FN_LIMITED_SPEED   = 2'h2,
    FN_LIMITED_POS     = 2'h3
  } sdm_func_t;

  // register map
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  ADDR_FUNC     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_CTRL     = 8'h10;
  localparam logic [7:0]  ADDR_OUT      = 8'h14;
  localparam logic [9:0]  FUNC_RST      = 10'h000;
  localparam logic [2:0]  OUT_RST       = 3'h0;

  // status fields
  localparam int unsigned ST_OK_LSB   = 8;
  localparam int unsigned ST_GUARD    = 16;
  localparam int unsigned ST_TEACH    = 17;
  localparam int unsigned ST_ESTOP    = 18;
  localparam int unsigned ST_INHIBIT  = 19;
  localparam int unsigned ST_SETTLED  = 20;

  // interrupt bits
  localparam int unsigned IRQ_W     = 11;
  localparam int unsigned IRQ_GUARD = 8;
  localparam int unsigned IRQ_TEACH = 9;
  localparam int unsigned IRQ_ESTOP = 10;

  // control bits
  localparam int unsigned CTRL_ESTOP_RESET = 0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : sdm_pkg

//--- core/sdm_pair.sv
// one redundant channel pair: synchroniser, test pulse filter, mismatch timer
module sdm_pair
  import sdm_pkg::*;
#(
  parameter int unsigned FILT_CYC = FILT_CYC_DEF,
  parameter int unsigned DISC_CYC = DISC_CYC_DEF
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // raw channel levels from the terminals
  input  wire logic pri_raw,
  input  wire logic sec_raw,
  // filtered levels and sticky mismatch error
  output logic      pri_filt,
  output logic      sec_filt,
  output logic      disc_err
);

  logic [1:0]             s1_r, s2_r;
  logic [1:0]             filt_r, filt_nxt;
  logic [1:0][FCNT_W-1:0] fcnt_r, fcnt_nxt;
  logic [DCNT_W-1:0]      dcnt_r, dcnt_nxt;
  logic                   err_r, err_nxt;

  always_comb begin
    filt_nxt = filt_r;
    fcnt_nxt = fcnt_r;
    // short dips are ignored until they outlast the longest test pulse
    for (int i = 0; i < 2; i++) begin
      if (s2_r[i] == filt_r[i]) begin
        fcnt_nxt[i] = '0;
      end else if (fcnt_r[i] == FCNT_W'(FILT_CYC - 1)) begin
        filt_nxt[i] = s2_r[i];
        fcnt_nxt[i] = '0;
      end else begin
        fcnt_nxt[i] = fcnt_r[i] + 1'b1;
      end
    end
    // mismatch timer runs on filtered levels only
    dcnt_nxt = '0;
    err_nxt  = err_r;
    if (filt_r[0] != filt_r[1]) begin
      if (dcnt_r == DCNT_W'(DISC_CYC - 1)) begin
        err_nxt  = 1'b1;
        dcnt_nxt = dcnt_r;
      end else begin
        dcnt_nxt = dcnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r   <= 2'h0;
      s2_r   <= 2'h0;
      filt_r <= 2'h0;
      fcnt_r <= '0;
      dcnt_r <= '0;
      // only a restart clears the error
      err_r  <= 1'b0;
    end else begin
      // two-stage synchroniser
      s1_r   <= {sec_raw, pri_raw};
      s2_r   <= s1_r;
      filt_r <= filt_nxt;
      fcnt_r <= fcnt_nxt;
      dcnt_r <= dcnt_nxt;
      err_r  <= err_nxt;
    end
  end

  assign pri_filt = filt_r[0];
  assign sec_filt = filt_r[1];
  assign disc_err = err_r;

endmodule : sdm_pair

//--- verification/sdm_monitor_properties.sv
// concurrent checks on the discrepancy monitor top ports
module sdm_monitor_properties
  import sdm_pkg::*;
#(
  parameter int unsigned FILT_CYC = FILT_CYC_DEF,
  parameter int unsigned DISC_CYC = DISC_CYC_DEF
) (
  // clock, reset, bus handshakes
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  // terminals
  input wire logic [NUM_IN-1:0]  guard_input_primary_channel,
  input wire logic [NUM_IN-1:0]  guard_input_secondary_channel,
  input wire logic [NUM_OUT-1:0] guard_output_primary_channel,
  input wire logic [NUM_OUT-1:0] guard_output_secondary_channel,
  input wire logic [NUM_OUT-1:0] out_readback_primary,
  input wire logic [NUM_OUT-1:0] out_readback_secondary,
  input wire logic               hold_release_input,
  // status
  input wire logic               motion_inhibit,
  input wire logic               guard_open_status,
  input wire logic               estop_active,
  input wire logic               discrepancy_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        mism;
  logic        opened;
  logic [31:0] mm_r, mm_nxt, op_r, op_nxt;
  logic [7:0]  seen_r, seen_nxt;
  //////////////////////////////////////////////////////////////////////////////
  // run lengths of pin mismatch and of any open contact
  always_comb begin
    mism = |(guard_input_primary_channel ^ guard_input_secondary_channel)
         | |(out_readback_primary ^ out_readback_secondary);
    opened = ~&(guard_input_primary_channel & guard_input_secondary_channel);
    mm_nxt = mism ? mm_r + 32'h1 : 32'h0;
    op_nxt = opened ? op_r + 32'h1 : 32'h0;
    // a long opening stays credited a short while for the filter latency
    seen_nxt = (op_r >= FILT_CYC - 1) ? 8'h1F : (seen_r != 8'h00 ? seen_r - 8'h01 : 8'h00);
  end
  always_ff @(posedge aclk) begin
    mm_r   <= aresetn ? mm_nxt : 32'h0;
    op_r   <= aresetn ? op_nxt : 32'h0;
    seen_r <= aresetn ? seen_nxt : 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_err_sticky: assert property (discrepancy_error |=> discrepancy_error)
    else $error("discrepancy error dropped");
  chk_err_outputs_off: assert property (discrepancy_error |-> motion_inhibit &&
    guard_output_primary_channel == 3'h0 && guard_output_secondary_channel == 3'h0)
    else $error("error without inhibit or with outputs on");
  chk_guard_inhibit: assert property (guard_open_status |-> motion_inhibit)
    else $error("guard latched but motion allowed");
  chk_guard_hold: assert property ((!hold_release_input)[*4] ##0 guard_open_status
    |=> guard_open_status) else $error("guard latch cleared with release open");
  chk_err_not_early: assert property ($rose(discrepancy_error) |-> mm_r >= DISC_CYC)
    else $error("discrepancy error raised too early");
  chk_err_not_late: assert property (mm_r >= DISC_CYC + FILT_CYC + 12
    |-> discrepancy_error) else $error("discrepancy error missing");
  chk_pulse_filter: assert property ($rose(guard_open_status) || $rose(estop_active)
    |-> seen_r != 8'h00) else $error("short pulse tripped a channel");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule : sdm_monitor_properties

bind sdm_monitor sdm_monitor_properties #(.FILT_CYC(FILT_CYC), .DISC_CYC(DISC_CYC)) sdm_props_i (
  .*);

//--- verification/sdm_field.sv
// field side model: dual-contact switches with test pulses, output read-back
module sdm_field
  import sdm_pkg::*;
#(
  // scaled: pulse narrower than the filter, gap far wider than the pulse
  parameter int unsigned PULSE_W   = 5,
  parameter int unsigned PULSE_GAP = 40
) (
  // clock and commands
  input wire logic               aclk,
  input wire logic [NUM_IN-1:0]  closed_cmd,
  input wire logic [NUM_IN-1:0]  pulse_en,
  input wire logic [NUM_OUT-1:0] rb_fault,
  // terminals
  output logic [NUM_IN-1:0]      in_pri,
  output logic [NUM_IN-1:0]      in_sec,
  input wire logic [NUM_OUT-1:0] out_pri,
  input wire logic [NUM_OUT-1:0] out_sec,
  output logic [NUM_OUT-1:0]     rb_pri,
  output logic [NUM_OUT-1:0]     rb_sec
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  always @(posedge aclk) begin
    cnt <= (cnt == PULSE_GAP - 1) ? 0 : cnt + 1;
  end
  assign in_pri = closed_cmd & ~(pulse_en & {NUM_IN{cnt < PULSE_W}});
  assign in_sec = closed_cmd;
  // a stuck-open secondary read-back contact when commanded
  assign rb_pri = out_pri;
  assign rb_sec = out_sec & ~rb_fault;
endmodule : sdm_field

//--- verification/tb_top.sv
// self-checking bench for the discrepancy monitor
module tb_top;
  import sdm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned FC = 8;
  localparam int unsigned DC = 64;
  localparam int unsigned LAT = 30;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, motion_inhibit, guard_open_status, teach_latch_status;
  logic estop_active, discrepancy_error;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] guard_input_primary_channel, guard_input_secondary_channel;
  logic [4:0] closed_cmd = 5'h1D, pulse_en = 5'h00;
  logic [2:0] guard_output_primary_channel, guard_output_secondary_channel;
  logic [2:0] out_readback_primary, out_readback_secondary, rb_fault = 3'h0;
  logic hold_release_input = 0, teach_mode_in = 0;
  int n_fail = 0, total_checks = 0;
  always #2 aclk = ~aclk;
  sdm_monitor #(.FILT_CYC(FC), .DISC_CYC(DC)) sdm_monitor_i (.*);
  sdm_field sdm_field_i (.aclk(aclk), .closed_cmd(closed_cmd), .pulse_en(pulse_en),
    .rb_fault(rb_fault), .in_pri(guard_input_primary_channel),
    .in_sec(guard_input_secondary_channel), .out_pri(guard_output_primary_channel),
    .out_sec(guard_output_secondary_channel), .rb_pri(out_readback_primary),
    .rb_sec(out_readback_secondary));
  //////////////////////////////////////////////////////////////////////////////
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  // stops on a falling edge, where outputs are settled
  task cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    {ad, wd} = 2'b00;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ad = ad || s_axi_awready === 1'b1;
      wd = wd || s_axi_wready === 1'b1;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    chk_val({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
          input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    chk_val(s_axi_rdata & m, e);
    chk_val({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : rd
  task test_done(input string s);
    $display("test %s done", s);
  endtask : test_done
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // pair0 stop, pairs 1-2 guard, pair3 speed, pair4 position, before settling
    wr(ADDR_FUNC, 32'h394, RESP_OKAY);
    rd(ADDR_FUNC, 32'hFFFFFFFF, 32'h394, RESP_OKAY);
    rd(ADDR_IRQ_MASK, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(ADDR_OUT, 32'hFFFFFFFF, 32'h0, RESP_OKAY);
    rd(8'h18, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
    cyc(LAT);
    chk_bit(guard_open_status, 1'b1);
    chk_bit(motion_inhibit, 1'b1);
    @(posedge aclk) closed_cmd <= 5'h1F;
    cyc(LAT);
    chk_bit(guard_open_status, 1'b1);
    @(posedge aclk) hold_release_input <= 1'b1;
    cyc(10);
    chk_bit(guard_open_status, 1'b0);
    chk_bit(motion_inhibit, 1'b0);
    test_done("power_up_guard");
    @(posedge aclk) begin
      hold_release_input <= 1'b0;
      teach_mode_in <= 1'b1;
      closed_cmd <= 5'h19;
    end
    cyc(LAT);
    chk_bit(teach_latch_status, 1'b1);
    @(posedge aclk) teach_mode_in <= 1'b0;
    cyc(10);
    chk_bit(teach_latch_status, 1'b1);
    @(posedge aclk) hold_release_input <= 1'b1;
    cyc(10);
    chk_bit(teach_latch_status, 1'b0);
    chk_bit(motion_inhibit, 1'b1);
    @(posedge aclk) closed_cmd <= 5'h1B;
    cyc(LAT);
    chk_bit(guard_open_status, 1'b1);
    @(posedge aclk) closed_cmd <= 5'h1F;
    cyc(LAT);
    chk_bit(guard_open_status, 1'b0);
    chk_bit(motion_inhibit, 1'b0);
    @(posedge aclk) hold_release_input <= 1'b0;
    test_done("teach_and_guards");
    rd(ADDR_IRQ_STAT, 32'h7FF, 32'h300, RESP_OKAY);
    chk_bit(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h100, RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h100, RESP_OKAY);
    rd(ADDR_IRQ_STAT, 32'h7FF, 32'h200, RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b0);
    wr(ADDR_IRQ_STAT, 32'h200, RESP_OKAY);
    test_done("interrupts");
    @(posedge aclk) pulse_en <= 5'h03;
    cyc(DC * 4);
    rd(ADDR_IRQ_STAT, 32'h7FF, 32'h0, RESP_OKAY);
    chk_bit(estop_active, 1'b0);
    @(posedge aclk) pulse_en <= 5'h00;
    test_done("test_pulses");
    wr(ADDR_IRQ_MASK, 32'h400, RESP_OKAY);
    @(posedge aclk) closed_cmd <= 5'h1E;
    cyc(LAT);
    chk_bit(estop_active, 1'b1);
    chk_bit(irq, 1'b1);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    cyc(5);
    chk_bit(estop_active, 1'b1);
    @(posedge aclk) closed_cmd <= 5'h1F;
    cyc(LAT);
    chk_bit(motion_inhibit, 1'b1);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    cyc(5);
    chk_bit(estop_active, 1'b0);
    wr(ADDR_IRQ_STAT, 32'h400, RESP_OKAY);
    cyc(2);
    chk_bit(irq, 1'b0);
    test_done("estop");
    wr(ADDR_OUT, 32'h7, RESP_OKAY);
    cyc(2);
    chk_val({29'h0, guard_output_secondary_channel}, 32'h7);
    @(posedge aclk) rb_fault <= 3'h4;
    cyc(DC);
    chk_bit(discrepancy_error, 1'b0);
    cyc(FC + 20);
    chk_bit(discrepancy_error, 1'b1);
    chk_val({29'h0, guard_output_primary_channel}, 32'h0);
    rd(ADDR_STATUS, 32'hFF, 32'h80, RESP_OKAY);
    @(posedge aclk) rb_fault <= 3'h0;
    cyc(DC);
    chk_bit(discrepancy_error, 1'b1);
    @(posedge aclk) aresetn <= 1'b0;
    cyc(16);
    @(posedge aclk) aresetn <= 1'b1;
    cyc(LAT);
    chk_bit(discrepancy_error, 1'b0);
    test_done("discrepancy");
    end_sim();
  end
endmodule : tb_top
